// ===== src/ubec_top.sv
// Baud generator, divisor ports, fallback logic and loopback routing.
// Assumes ref_tick pulses once per 24 MHz reference period, synchronous to
// aclk, and that the serial engines sit outside this block.

`timescale 1ns/1ps
`default_nettype none

module ubec_top
   import ubec_pkg::*;
#(
   parameter int BIT_DIV_P = ubec_pkg::BIT_DIV
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic awvalid,
   output logic awready,
   input wire logic [ubec_pkg::AXI_ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [ubec_pkg::AXI_DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [ubec_pkg::AXI_ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [ubec_pkg::AXI_DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // Reference, baud and mode outputs
   input wire logic ref_tick,
   output logic sixteen_x_bit_clock,
   output logic bit_tick,
   output logic extended_mode_select,
   // FIFO levels from the data path
   input wire logic [ubec_pkg::LEVEL_W-1:0] transmit_fifo_level,
   input wire logic [ubec_pkg::LEVEL_W-1:0] receive_fifo_level,
   // Internal serial engines
   input wire logic tx_serial_int,
   input wire logic ir_tx_int,
   output logic rx_serial_int,
   output logic ir_rx_int,
   output logic cts_int,
   output logic dsr_int,
   output logic ri_int,
   output logic dcd_int,
   // Pins
   input wire logic sin_pin,
   input wire logic irrx_pin,
   input wire logic cts_n_pin,
   input wire logic dsr_n_pin,
   input wire logic ri_n_pin,
   input wire logic dcd_n_pin,
   output logic sout_pin,
   output logic irtx_pin,
   output logic dtr_n_pin,
   output logic rts_n_pin
);
   import ubec_pkg::*;

   // ***********************************************************
   // State
   // ***********************************************************
   logic [7:0] line_control_reg;
   logic [7:0] modem_control_reg;
   logic loop_en;
   logic tx_during_loopback_enable;
   logic baud_generator_test;
   logic [1:0] prescale_select;
   logic div_lock;
   logic [7:0] div_low;
   logic [7:0] div_high;
   logic [7:0] scratch_low;
   logic [7:0] scratch_high;
   logic aw_full;
   logic w_full;
   logic [AXI_ADDR_W-1:0] aw_addr_h;
   logic [7:0] w_byte_h;
   logic w_strb0_h;
   logic [4:0] pre_acc;
   logic pre_tick;
   logic [15:0] baud_cnt;
   logic [3:0] bit_cnt;

   // ***********************************************************
   // Decode and fallback
   // ***********************************************************
   logic wr_go;
   logic wr_err;
   logic wr_en;
   logic wr_win2;
   logic [2:0] wr_idx;
   logic ar_hs;
   logic rd_err;
   logic rd_win2;
   logic [2:0] ar_idx;
   logic scratch_sel;
   logic wr_leg_div;
   logic rd_leg_div;
   logic legacy_acc;
   logic fb_ext;
   logic fb_non;
   logic wr_div_low;
   logic wr_div_high;
   logic [15:0] next_div;
   logic [7:0] rd_byte;

   assign wr_go = aw_full && w_full && !bvalid;
   assign wr_err = |aw_addr_h[AXI_ADDR_W-1:TOP_LSB];
   assign wr_en = wr_go && !wr_err && w_strb0_h;
   assign wr_win2 = aw_addr_h[WIN_BIT];
   assign wr_idx = aw_addr_h[WIN_BIT-1:IDX_LSB];
   assign ar_hs = arvalid && arready;
   assign rd_err = |araddr[AXI_ADDR_W-1:TOP_LSB];
   assign rd_win2 = araddr[WIN_BIT];
   assign ar_idx = araddr[WIN_BIT-1:IDX_LSB];
   // Locked divisor is only honoured outside extended mode
   assign scratch_sel = div_lock && !extended_mode_select; // see [R25]
   // Legacy window, offsets 0 and 1, with bank switch set
   assign wr_leg_div = wr_go && !wr_err && !wr_win2 && (wr_idx <= IDX_DIV_HIGH)
      && line_control_reg[LCR_BANK_SWITCH]; // see [R26]
   assign rd_leg_div = ar_hs && !rd_err && !rd_win2 && (ar_idx <= IDX_DIV_HIGH)
      && line_control_reg[LCR_BANK_SWITCH]; // see [R26]
   assign legacy_acc = wr_leg_div || rd_leg_div; // see [R7]
   assign fb_ext = legacy_acc && extended_mode_select; // see [R8]
   assign fb_non = legacy_acc && !extended_mode_select && !div_lock; // see [R8] [R9]
   // Alternate ports never feed legacy_acc, so they never change mode
   assign wr_div_low = wr_en && (wr_idx == IDX_DIV_LOW)
      && (wr_win2 || (wr_leg_div && !scratch_sel)); // see [R10]
   assign wr_div_high = wr_en && (wr_idx == IDX_DIV_HIGH)
      && (wr_win2 || (wr_leg_div && !scratch_sel)); // see [R10] [R11]
   assign next_div = {wr_div_high ? w_byte_h : div_high, wr_div_low ? w_byte_h : div_low};

   // ***********************************************************
   // AXI4-Lite write channel
   // ***********************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_full <= 1'b0;
         aw_addr_h <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_full <= 1'b1;
         aw_addr_h <= awaddr;
      end else if (wr_go) begin
         aw_full <= 1'b0;
      end else if (!aw_full) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b0;
         w_full <= 1'b0;
         w_byte_h <= BYTE_RESET;
         w_strb0_h <= 1'b0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_full <= 1'b1;
         w_byte_h <= wdata[7:0];
         w_strb0_h <= wstrb[0];
      end else if (wr_go) begin
         w_full <= 1'b0;
      end else if (!w_full) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ***********************************************************
   // AXI4-Lite read channel
   // ***********************************************************
   always_comb begin
      rd_byte = BYTE_RESET;
      if (rd_win2) begin
         case (ar_idx) // see [R12]
            IDX_DIV_LOW: rd_byte = div_low;
            IDX_DIV_HIGH: rd_byte = div_high;
            IDX_EXCR_ONE: rd_byte = {baud_generator_test, 1'b0, tx_during_loopback_enable,
               loop_en, 3'b000, extended_mode_select}; // see [R16] [R17]
            IDX_LINE_CTRL: rd_byte = line_control_reg; // see [R13]
            IDX_EXCR_TWO: rd_byte = {div_lock, 1'b0, prescale_select, 4'h0};
            IDX_TX_LEVEL: rd_byte = {3'b000, transmit_fifo_level};
            IDX_RX_LEVEL: rd_byte = {3'b000, receive_fifo_level};
            default: rd_byte = BYTE_RESET;
         endcase
      end else begin
         case (ar_idx)
            IDX_DIV_LOW: rd_byte = !line_control_reg[LCR_BANK_SWITCH] ? BYTE_RESET :
               scratch_sel ? scratch_low : div_low; // see [R25]
            IDX_DIV_HIGH: rd_byte = !line_control_reg[LCR_BANK_SWITCH] ? BYTE_RESET :
               scratch_sel ? scratch_high : div_high;
            IDX_LINE_CTRL: rd_byte = line_control_reg; // see [R13]
            IDX_MODEM_CTRL: rd_byte = {modem_control_reg[7:5], loop_en, modem_control_reg[3:0]};
            default: rd_byte = BYTE_RESET;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (ar_hs) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= {24'h000000, rd_err ? BYTE_RESET : rd_byte};
         rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid) begin
         if (rready) begin
            rvalid <= 1'b0;
         end
      end else begin
         arready <= 1'b1;
      end
   end

   // ***********************************************************
   // Control registers
   // ***********************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_control_reg <= BYTE_RESET;
      end else if (wr_en && (wr_idx == IDX_LINE_CTRL)) begin
         line_control_reg <= w_byte_h; // see [R13]
      end
   end

   // Fallback clears are applied after a same-cycle write, so they win
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         extended_mode_select <= 1'b0; // see [R14]
         tx_during_loopback_enable <= 1'b0;
         baud_generator_test <= 1'b0;
      end else begin
         if (wr_en && wr_win2 && (wr_idx == IDX_EXCR_ONE)) begin
            extended_mode_select <= w_byte_h[X1_EXT]; // see [R15]
            tx_during_loopback_enable <= w_byte_h[X1_ETD];
            baud_generator_test <= w_byte_h[X1_BAUD_GENERATOR_TEST];
         end
         if (fb_ext) begin
            extended_mode_select <= 1'b0; // see [R8]
         end
         if (fb_ext || fb_non) begin
            tx_during_loopback_enable <= 1'b0; // see [R8]
            baud_generator_test <= 1'b0;
         end
      end
   end

   // One loopback flop behind both control one and modem control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loop_en <= 1'b0;
      end else begin
         if (wr_en && wr_win2 && (wr_idx == IDX_EXCR_ONE)) begin
            loop_en <= w_byte_h[X1_LOOP]; // see [R17]
         end else if (wr_en && !wr_win2 && (wr_idx == IDX_MODEM_CTRL)
            && !extended_mode_select) begin
            loop_en <= w_byte_h[MC_LOOP]; // see [R17]
         end
         // Also modem control bit 4, so extended fallback clears it
         if (fb_ext) begin
            loop_en <= 1'b0; // see [R8]
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         modem_control_reg <= BYTE_RESET;
      end else begin
         if (wr_en && !wr_win2 && (wr_idx == IDX_MODEM_CTRL)) begin
            modem_control_reg <= w_byte_h;
         end
         if (fb_ext) begin
            modem_control_reg[7:2] <= 6'h00; // see [R8]
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescale_select <= PRESCALE_SELECT_13;
         div_lock <= 1'b0;
      end else begin
         if (wr_en && wr_win2 && (wr_idx == IDX_EXCR_TWO)) begin
            prescale_select <= w_byte_h[X2_PRE_HI:X2_PRE_LO]; // see [R24]
            div_lock <= w_byte_h[X2_LOCK];
         end
         if (fb_ext || fb_non) begin
            prescale_select <= PRESCALE_SELECT_13; // see [R8]
         end
      end
   end

   // Divisor has no reset; software must load it first
   always_ff @(posedge aclk) begin
      if (wr_div_low) begin
         div_low <= w_byte_h; // see [R6] [R4]
      end
      if (wr_div_high) begin
         div_high <= w_byte_h; // see [R6]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scratch_low <= BYTE_RESET;
         scratch_high <= BYTE_RESET;
      end else if (wr_en && wr_leg_div && scratch_sel) begin
         if (wr_idx == IDX_DIV_LOW) begin
            scratch_low <= w_byte_h; // see [R25] [R9]
         end else begin
            scratch_high <= w_byte_h;
         end
      end
   end

   // ***********************************************************
   // Prescaler and baud counter
   // ***********************************************************
   logic [4:0] pre_step;
   logic [4:0] pre_sum;

   always_comb begin
      case (prescale_select) // see [R24] [R1]
         PRESCALE_SELECT_1625: pre_step = PRE_STEP_1625;
         PRESCALE_SELECT_1: pre_step = PRE_STEP_1;
         default: pre_step = PRE_STEP_13; // Reserved code runs as 13
      endcase
   end
   assign pre_sum = pre_acc + pre_step;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_acc <= 5'h00;
         pre_tick <= 1'b0;
      end else if (ref_tick && (pre_sum >= PRE_MOD)) begin
         pre_acc <= pre_sum - PRE_MOD; // see [R1]
         pre_tick <= 1'b1;
      end else begin
         pre_acc <= ref_tick ? pre_sum : pre_acc;
         pre_tick <= 1'b0;
      end
   end

   // Divisor zero is illegal; it behaves like one here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_cnt <= 16'h0000;
         sixteen_x_bit_clock <= 1'b0;
      end else if (wr_div_low || wr_div_high) begin
         baud_cnt <= next_div; // see [R5] [R11] [R3]
         sixteen_x_bit_clock <= 1'b0;
      end else if (pre_tick && (baud_cnt <= 16'h0001)) begin
         baud_cnt <= {div_high, div_low}; // see [R27] [R2]
         sixteen_x_bit_clock <= 1'b1;
      end else begin
         baud_cnt <= pre_tick ? baud_cnt - 16'h0001 : baud_cnt;
         sixteen_x_bit_clock <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bit_cnt <= 4'h0;
         bit_tick <= 1'b0;
      end else if (sixteen_x_bit_clock) begin
         bit_cnt <= (bit_cnt == 4'(BIT_DIV_P - 1)) ? 4'h0 : bit_cnt + 4'h1; // see [R2]
         bit_tick <= (bit_cnt == 4'(BIT_DIV_P - 1));
      end else begin
         bit_tick <= 1'b0;
      end
   end

   // ***********************************************************
   // Loopback and pin routing
   // ***********************************************************
   logic tx_pins_live;
   assign tx_pins_live = !loop_en || tx_during_loopback_enable; // see [R22]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sout_pin <= 1'b1;
         irtx_pin <= 1'b0;
         rx_serial_int <= 1'b1;
         ir_rx_int <= 1'b0;
      end else begin
         sout_pin <= tx_pins_live ? tx_serial_int : 1'b1; // see [R20]
         irtx_pin <= tx_pins_live ? ir_tx_int : 1'b0; // see [R20]
         rx_serial_int <= loop_en ? tx_serial_int : sin_pin; // see [R18]
         ir_rx_int <= loop_en ? ir_tx_int : irrx_pin; // see [R18]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cts_int <= 1'b0;
         dsr_int <= 1'b0;
         ri_int <= 1'b0;
         dcd_int <= 1'b0;
      end else if (loop_en && extended_mode_select) begin
         cts_int <= modem_control_reg[MC_RTS]; // see [R19]
         dcd_int <= modem_control_reg[MC_RTS];
         dsr_int <= modem_control_reg[MC_DTR];
         ri_int <= modem_control_reg[MC_DTR];
      end else if (loop_en) begin
         cts_int <= modem_control_reg[MC_RTS]; // see [R21]
         dsr_int <= modem_control_reg[MC_DTR];
         ri_int <= modem_control_reg[MC_OUT1];
         dcd_int <= modem_control_reg[MC_OUT2];
      end else begin
         cts_int <= !cts_n_pin;
         dsr_int <= !dsr_n_pin;
         ri_int <= !ri_n_pin;
         dcd_int <= !dcd_n_pin;
      end
   end

   // Modem outputs go inactive during loopback, except DTR while baud generator test routes the 16x tick to it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dtr_n_pin <= 1'b1;
         rts_n_pin <= 1'b1;
      end else begin
         dtr_n_pin <= baud_generator_test ? sixteen_x_bit_clock :
            !(modem_control_reg[MC_DTR] && !loop_en); // see [R23]
         rts_n_pin <= !(modem_control_reg[MC_RTS] && !loop_en);
      end
   end

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ext_hit;
      legacy_acc && extended_mode_select;
   endsequence
   sequence s_locked_hit;
      legacy_acc && !extended_mode_select && div_lock;
   endsequence

   prescale_one_a: assert property (ref_tick && prescale_select == PRESCALE_SELECT_1 |=> pre_tick) // see [R1]
      else $error("prescale of one missed a reference tick");
   prescale_src_a: assert property (pre_tick |-> $past(ref_tick)) // see [R24]
      else $error("prescaled tick without reference tick");
   // Byte-wise, since the other divisor byte is unknown until first written
   div_reload_a: assert property (wr_div_low |=> baud_cnt[7:0] == $past(w_byte_h)) // see [R5]
      else $error("divisor low write did not reload counter");
   reload_high_a: assert property (wr_div_high |=> baud_cnt[15:8] == $past(w_byte_h)) // see [R11]
      else $error("divisor high write did not reload counter");
   terminal_a: assert property (pre_tick && baud_cnt == 16'h0001 && !wr_div_low && !wr_div_high
      |=> sixteen_x_bit_clock && baud_cnt == {div_high, div_low}) // see [R27]
      else $error("terminal count did not tick and reload");
   fallback_ext_a: assert property (s_ext_hit |=> !extended_mode_select && !baud_generator_test
      && !tx_during_loopback_enable && prescale_select == PRESCALE_SELECT_13 && !loop_en
      && modem_control_reg[7:2] == 6'h00) // see [R8]
      else $error("extended fallback left bits set");
   locked_a: assert property ((s_locked_hit and !(wr_en && wr_win2)) |=> div_lock
      && $stable(prescale_select) && $stable(baud_generator_test)
      && $stable(tx_during_loopback_enable)) // see [R9]
      else $error("locked legacy access changed control state");
   alt_mode_a: assert property (wr_win2 && wr_en && wr_idx <= IDX_DIV_HIGH && !rd_leg_div
      |=> $stable(extended_mode_select)) // see [R10]
      else $error("alternate divisor access changed mode");
   loop_tx_a: assert property (loop_en && !tx_during_loopback_enable |=> sout_pin && !irtx_pin) // see [R20]
      else $error("transmit pins not parked in loopback");
   loop_ext_a: assert property (loop_en && extended_mode_select
      |=> dsr_int == $past(modem_control_reg[MC_DTR]) && ri_int == dsr_int
      && dcd_int == $past(modem_control_reg[MC_RTS]) && cts_int == dcd_int) // see [R19]
      else $error("extended loopback modem wiring wrong");
   baud_generator_test_a: assert property (baud_generator_test |=> dtr_n_pin == $past(sixteen_x_bit_clock)) // see [R23]
      else $error("baud test output not on DTR");

endmodule

`default_nettype wire

// ===== src/ubec_pkg.sv
// Constants, register map and field positions of the baud generator and
// extended control block.
// Assumes a 32-bit AXI4-Lite master and a 100 MHz aclk.
//
// Function
// [R1] Prescaler divides the 24 MHz reference by 13, 1.625 or 1.
// [R2] Divisor makes a 16x tick; a further divide by 16 gives the bit rate.
// [R3] Software never programs a divisor of zero.
// [R4] Software loads the divisor before relying on the generator.
// [R5] Writing either divisor byte reloads the baud counter at once.
// [R6] Divisor bytes get no reset value.
// [R7] Legacy divisor read or write forces non-extended mode unless locked.
// [R8] Fallback clears the listed control bits, depending on mode before.
// [R9] Non-extended with lock set: legacy divisor access changes nothing.
// [R10] Alternate divisor ports reach the same divisor without mode change.
// [R11] Alternate high byte write takes effect immediately.
// [R12] Bank 2 decodes divisor, control one, line control, control two, levels.
// [R13] Line control location reads the same from every bank.
// [R14] Extended control one resets to zero.
// [R15] Control one bit 0 selects extended mode.
// [R16] Control one bits 3 to 1 and 6 read as zero.
// [R17] Control one bit 4 is loopback, shared with modem control bit 4.
// [R18] Loopback disconnects receive pins and feeds transmit outputs back.
// [R19] Extended loopback: DTR drives DSR and RI, RTS drives CTS and DCD.
// [R20] Loopback holds serial out high and infrared out low unless enabled.
// [R21] Loopback modem status comes from low modem control bits.
// [R22] Control one bit 5 lets the transmitter run during loopback.
// [R23] Control one bit 7 routes the baud generator to the DTR pin.
// [R24] Control two bits 5:4 select prescale 13, 1.625, reserved, 1.
// [R25] Lock bit 7 diverts legacy divisor accesses to two scratch registers.
// [R26] Line control bit 7 picks data ports or legacy divisor at 0 and 1.
// [R27] Counter counts down from divisor, one tick per terminal count.

package ubec_pkg;

   // ***********************************************************
   // Bus and decode
   // ***********************************************************
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;
   localparam int IDX_LSB = 2;
   localparam int WIN_BIT = 5;
   localparam int TOP_LSB = 6;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Register index inside a bank window
   localparam logic [2:0] IDX_DIV_LOW = 3'h0;
   localparam logic [2:0] IDX_DIV_HIGH = 3'h1;
   localparam logic [2:0] IDX_EXCR_ONE = 3'h2;
   localparam logic [2:0] IDX_LINE_CTRL = 3'h3;
   localparam logic [2:0] IDX_EXCR_TWO = 3'h4;
   localparam logic [2:0] IDX_RSVD = 3'h5;
   localparam logic [2:0] IDX_TX_LEVEL = 3'h6;
   localparam logic [2:0] IDX_RX_LEVEL = 3'h7;
   localparam logic [2:0] IDX_MODEM_CTRL = 3'h4;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int X1_EXT = 0;
   localparam int X1_LOOP = 4;
   localparam int X1_ETD = 5;
   localparam int X1_BAUD_GENERATOR_TEST = 7;
   localparam int X2_PRE_LO = 4;
   localparam int X2_PRE_HI = 5;
   localparam int X2_LOCK = 7;
   localparam int LCR_BANK_SWITCH = 7;
   localparam int MC_DTR = 0;
   localparam int MC_RTS = 1;
   localparam int MC_OUT1 = 2;
   localparam int MC_OUT2 = 3;
   localparam int MC_LOOP = 4;
   localparam int LEVEL_W = 5;

   // ***********************************************************
   // Reset values and timing
   // ***********************************************************
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [1:0] PRESCALE_SELECT_13 = 2'b00;
   localparam logic [1:0] PRESCALE_SELECT_1625 = 2'b01;
   localparam logic [1:0] PRESCALE_SELECT_RSVD = 2'b10;
   localparam logic [1:0] PRESCALE_SELECT_1 = 2'b11;
   // 1.625 = 13/8, so every prescale is a fraction 13/step
   localparam logic [4:0] PRE_MOD = 5'h0d;
   localparam logic [4:0] PRE_STEP_13 = 5'h01;
   localparam logic [4:0] PRE_STEP_1625 = 5'h08;
   localparam logic [4:0] PRE_STEP_1 = 5'h0d;
   localparam int REF_CLOCK_HZ = 24000000;
   localparam int BIT_DIV = 16;

endpackage

// ===== tb/ubec_peer.sv
// Serial line peer seen from the block's pins.
// Assumes the block samples these pins on aclk.
`timescale 1ns/1ps
`default_nettype none
module ubec_peer (
   // Pins toward the block
   output logic sin_pin,
   output logic irrx_pin,
   output logic cts_n_pin,
   output logic dsr_n_pin,
   output logic ri_n_pin,
   output logic dcd_n_pin
);
   // Idle mark and asserted modem lines, opposite to what loopback feeds back except on DSR and RI
   assign {sin_pin, irrx_pin, cts_n_pin, dsr_n_pin, ri_n_pin, dcd_n_pin} = 6'h20;
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench: AXI master, engine stubs and the peer.
// Assumes the peer drives all receive and modem pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ubec_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, ref_tick, sixteen_x_bit_clock, bit_tick, extended_mode_select;
   logic tx_serial_int, ir_tx_int, rx_serial_int, ir_rx_int, cts_int, dsr_int, ri_int, dcd_int;
   logic sin_pin, irrx_pin, cts_n_pin, dsr_n_pin, ri_n_pin, dcd_n_pin;
   logic sout_pin, irtx_pin, dtr_n_pin, rts_n_pin;
   logic [7:0] awaddr, araddr, v;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [4:0] transmit_fifo_level, receive_fifo_level;
   int errors, tests_run, n, k;
   ubec_top ubec_top_inst (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
      .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
      .rdata, .rresp, .ref_tick, .sixteen_x_bit_clock, .bit_tick, .extended_mode_select,
      .transmit_fifo_level, .receive_fifo_level, .tx_serial_int, .ir_tx_int, .rx_serial_int,
      .ir_rx_int, .cts_int, .dsr_int, .ri_int, .dcd_int, .sin_pin, .irrx_pin, .cts_n_pin,
      .dsr_n_pin, .ri_n_pin, .dcd_n_pin, .sout_pin, .irtx_pin, .dtr_n_pin, .rts_n_pin);
   ubec_peer ubec_peer_inst (.sin_pin, .irrx_pin, .cts_n_pin, .dsr_n_pin, .ri_n_pin, .dcd_n_pin);
   // ************************************
   // Clock, reference and bus tasks
   // ************************************
   initial begin
      aclk = 0;
      forever #5 aclk = ~aclk;
   end
   // Reference pulse every 4 cycles, so a prescale of 1 gives 4 cycles a step
   always @(posedge aclk) begin
      k <= (k + 1) % 4;
      ref_tick <= (k == 0);
   end
   task chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
      do @(posedge aclk) begin
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      r = bresp;
      bready <= 0;
      @(posedge aclk);
   endtask
   task rd(input logic [7:0] a);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge aclk) if (arready) arvalid <= 0; while (!rvalid);
      v = rdata[7:0]; r = rresp; rready <= 0;
      @(posedge aclk);
   endtask
   task per;
      do @(posedge aclk); while (!sixteen_x_bit_clock);
      n = 0;
      do begin @(posedge aclk); n++; end while (!sixteen_x_bit_clock);
   endtask
   // ************************************
   // Scenarios
   // ************************************
   task t_reset;
      rd(8'h28); chk(v, 8'h00);
      rd(8'h38); chk(v, 8'h15);
      rd(8'h40); chk(8'(r), 8'(RESP_SLVERR));
      wr(8'h48, 8'h5a);
      chk(8'(r), 8'(RESP_SLVERR));
   endtask
   task t_baud;
      wr(8'h30, 8'h30);
      chk(8'(r), 8'(RESP_OKAY));
      wr(8'h20, 8'h05); // Nonzero divisor, loaded before use
      wr(8'h24, 8'h00);
      per; chk(8'(n), 8'd20);
      wr(8'h20, 8'h03);
      wr(8'h24, 8'h00);
      per; chk(8'(n), 8'd12);
      do @(posedge aclk); while (!bit_tick);
      n = 0;
      do begin @(posedge aclk); n++; end while (!bit_tick);
      chk(8'(n), 8'd192);
   endtask
   task t_loop;
      wr(8'h28, 8'h11);
      wr(8'h10, 8'h01);
      ir_tx_int <= 1;
      repeat (3) @(posedge aclk);
      chk(8'(extended_mode_select), 8'h01);
      chk({6'h0, rx_serial_int, ir_rx_int}, 8'h01);
      chk({6'h0, sout_pin, irtx_pin}, 8'h02);
      chk({4'h0, dsr_int, ri_int, cts_int, dcd_int}, 8'h0c);
      chk({6'h0, dtr_n_pin, rts_n_pin}, 8'h03);
      wr(8'h28, 8'h31);
      repeat (3) @(posedge aclk);
      chk(8'(sout_pin), 8'h00);
   endtask
   task t_fallback;
      wr(8'h28, 8'hff);
      do @(posedge aclk); while (!sixteen_x_bit_clock);
      @(posedge aclk);
      chk(8'(dtr_n_pin), 8'h01);
      @(posedge aclk);
      chk(8'(dtr_n_pin), 8'h00);
      rd(8'h28); chk(v, 8'hb1);
      wr(8'h0c, 8'h80);
      rd(8'h2c); chk(v, 8'h80);
      rd(8'h00);
      rd(8'h28); chk(v, 8'h00);
      rd(8'h30); chk(v, 8'h00);
   endtask
   task t_lock;
      wr(8'h28, 8'h20);
      wr(8'h30, 8'h80);
      wr(8'h00, 8'h07);
      rd(8'h28); chk(v, 8'h20);
      rd(8'h20); chk(v, 8'h03);
   endtask
   task report_and_stop;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, tx_serial_int, ir_tx_int} = '0;
      {awaddr, araddr, wdata} = '0;
      aresetn = 0; wstrb = 4'hf;
      transmit_fifo_level = 5'h15; receive_fifo_level = 5'h0a;
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_reset; t_baud; t_loop; t_fallback; t_lock;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      report_and_stop;
   end
endmodule
`default_nettype wire
